//--- rtl/tcc_top.sv
module tcc_top
    import tcc_pkg::*;
#(
    parameter int NCH = 2
) (
    input  wire logic              I_CLK,
    input  wire logic              I_RST,
    input  wire logic [15:0]       I_COUNT,
    input  wire logic              I_TICK,
    input  wire logic              I_OVERFLOW,
    input  wire logic [NCH-1:0]    I_PIN,
    output logic      [NCH-1:0]    O_PIN_OUT,
    output logic      [NCH-1:0]    O_PIN_OE,
    output logic      [NCH-1:0]    O_IRQ,
    input  wire logic [7:0]        I_AWADDR,
    input  wire logic              I_AWVALID,
    output logic                   O_AWREADY,
    input  wire logic [31:0]       I_WDATA,
    input  wire logic [3:0]        I_WSTRB,
    input  wire logic              I_WVALID,
    output logic                   O_WREADY,
    output logic [1:0]             O_BRESP,
    output logic                   O_BVALID,
    input  wire logic              I_BREADY,
    input  wire logic [7:0]        I_ARADDR,
    input  wire logic              I_ARVALID,
    output logic                   O_ARREADY,
    output logic [31:0]            O_RDATA,
    output logic [1:0]             O_RRESP,
    output logic                   O_RVALID,
    input  wire logic              I_RREADY
);

    // =====================================================
    // decode
    function automatic logic [2:0] reg_index(input logic [7:0] a);
        case (a)
            OFS_SC0: reg_index = 3'h0;
            OFS_SC1: reg_index = 3'h1;
            OFS_HI0: reg_index = 3'h2;
            OFS_LO0: reg_index = 3'h3;
            OFS_HI1: reg_index = 3'h4;
            OFS_LO1: reg_index = 3'h5;
            default: reg_index = IDX_NONE;
        endcase
    endfunction

    function automatic tcc_mode_type chan_mode(input logic [7:0] sc, input logic buf0);
        if (sc[BIT_ELSH:BIT_ELSL] == 2'h0) begin
            chan_mode = MODE_PRESET;
        end else if (sc[BIT_MSA] || buf0) begin
            chan_mode = MODE_COMPARE;
        end else begin
            chan_mode = MODE_CAPTURE;
        end
    endfunction

    // =====================================================
    // state
    logic              awready_q, awready_d;
    logic              wready_q,  wready_d;
    logic              have_aw_q, have_aw_d;
    logic              have_w_q,  have_w_d;
    logic [7:0]        awaddr_q,  awaddr_d;
    logic [7:0]        wbyte_q,   wbyte_d;
    logic              wlane_q,   wlane_d;
    logic              bvalid_q,  bvalid_d;
    logic [1:0]        bresp_q,   bresp_d;
    logic              arready_q, arready_d;
    logic              rvalid_q,  rvalid_d;
    logic [31:0]       rdata_q,   rdata_d;
    logic [1:0]        rresp_q,   rresp_d;

    logic              wr_en;
    logic [2:0]        wr_idx;
    logic              rd_en;
    logic [2:0]        rd_idx;

    logic [7:0]        sc_q     [NCH];
    logic [7:0]        sc_d     [NCH];
    logic [15:0]       val_q    [NCH];
    logic [15:0]       val_d    [NCH];
    logic [15:0]       shadow_q, shadow_d;
    logic [NCH-1:0]    armed_q,  armed_d;
    logic [NCH-1:0]    block_q,  block_d;
    logic [NCH-1:0]    inhib_q,  inhib_d;
    logic [NCH-1:0]    maxeff_q, maxeff_d;
    logic [NCH-1:0]    pin_q,    pin_d;
    logic [NCH-1:0]    oe_q,     oe_d;
    logic [NCH-1:0]    irq_q,    irq_d;
    logic [NCH-1:0]    s1_q, s2_q, s3_q;
    logic [NCH-1:0]    lvl_q,    lvl_d;

    // =====================================================
    // bus slave
    always_comb begin
        awready_d = awready_q;
        wready_d  = wready_q;
        have_aw_d = have_aw_q;
        have_w_d  = have_w_q;
        awaddr_d  = awaddr_q;
        wbyte_d   = wbyte_q;
        wlane_d   = wlane_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        arready_d = arready_q;
        rvalid_d  = rvalid_q;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        wr_en     = 1'b0;
        wr_idx    = IDX_NONE;
        rd_en     = 1'b0;
        rd_idx    = IDX_NONE;
        if (I_AWVALID && awready_q) begin
            awaddr_d  = I_AWADDR;
            have_aw_d = 1'b1;
            awready_d = 1'b0;
        end
        if (I_WVALID && wready_q) begin
            wbyte_d  = I_WDATA[7:0];
            wlane_d  = I_WSTRB[0];
            have_w_d = 1'b1;
            wready_d = 1'b0;
        end
        if (have_aw_q && have_w_q && !bvalid_q) begin
            wr_idx    = reg_index(awaddr_q);
            wr_en     = wlane_q && (wr_idx != IDX_NONE);
            bresp_d   = (wr_idx == IDX_NONE) ? RESP_ERR : RESP_OKAY;
            bvalid_d  = 1'b1;
            have_aw_d = 1'b0;
            have_w_d  = 1'b0;
        end
        if (bvalid_q && I_BREADY) begin
            bvalid_d  = 1'b0;
            awready_d = 1'b1;
            wready_d  = 1'b1;
        end
        if (I_ARVALID && arready_q) begin
            rd_idx    = reg_index(I_ARADDR);
            rd_en     = (rd_idx != IDX_NONE);
            rresp_d   = rd_en ? RESP_OKAY : RESP_ERR;
            rvalid_d  = 1'b1;
            arready_d = 1'b0;
            rdata_d   = 32'h0000_0000;
            case (rd_idx)
                3'h0: rdata_d[7:0] = sc_q[0];
                3'h1: rdata_d[7:0] = sc_q[0][BIT_MSB] ? 8'h00 : sc_q[1];
                3'h2: rdata_d[7:0] = val_q[0][15:8];
                3'h3: rdata_d[7:0] = val_q[0][7:0];
                3'h4: rdata_d[7:0] = val_q[1][15:8];
                3'h5: rdata_d[7:0] = val_q[1][7:0];
                default: rdata_d = 32'h0000_0000;
            endcase
        end
        if (rvalid_q && I_RREADY) begin
            rvalid_d  = 1'b0;
            arready_d = 1'b1;
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            have_aw_q <= 1'b0;
            have_w_q  <= 1'b0;
            awaddr_q  <= 8'h00;
            wbyte_q   <= 8'h00;
            wlane_q   <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= RESP_OKAY;
        end else begin
            awready_q <= awready_d;
            wready_q  <= wready_d;
            have_aw_q <= have_aw_d;
            have_w_q  <= have_w_d;
            awaddr_q  <= awaddr_d;
            wbyte_q   <= wbyte_d;
            wlane_q   <= wlane_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            arready_q <= arready_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
        end
    end

    // =====================================================
    // pin synchroniser
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= I_PIN;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // =====================================================
    // channels
    always_comb begin
        logic          buf0;
        logic          live;
        logic          event_hit;
        logic          rise;
        logic          fall;
        logic          ovf_act;
        logic [15:0]   cmp_val;
        tcc_mode_type  mode;
        buf0      = sc_q[0][BIT_MSB];
        live      = 1'b0;
        event_hit = 1'b0;
        rise      = 1'b0;
        fall      = 1'b0;
        ovf_act   = 1'b0;
        cmp_val   = 16'h0000;
        mode      = MODE_PRESET;
        shadow_d  = shadow_q;
        // buffered compare reloads its shadow at overflow
        if (!buf0 || I_OVERFLOW) begin
            shadow_d = val_q[0];
        end
        for (int c = 0; c < NCH; c++) begin
            sc_d[c]     = sc_q[c];
            val_d[c]    = val_q[c];
            armed_d[c]  = armed_q[c];
            block_d[c]  = block_q[c];
            inhib_d[c]  = inhib_q[c];
            maxeff_d[c] = maxeff_q[c];
            pin_d[c]    = pin_q[c];
            lvl_d[c]    = lvl_q[c];
            live        = (c == 0) || !buf0;
            mode        = chan_mode(sc_q[c], (c == 0) && buf0);
            event_hit   = 1'b0;
            rise        = 1'b0;
            fall        = 1'b0;
            // an edge counts once two stages agree
            if (s2_q[c] == s3_q[c]) begin
                lvl_d[c] = s3_q[c];
                rise     = s3_q[c] && !lvl_q[c];
                fall     = !s3_q[c] && lvl_q[c];
            end
            cmp_val = ((c == 0) && buf0) ? shadow_q : val_q[c];
            if (!live) begin
                mode = MODE_PRESET;
            end
            if (I_OVERFLOW) begin
                maxeff_d[c] = sc_q[c][BIT_MAX];
            end
            unique case (mode)
                MODE_PRESET: begin
                    pin_d[c] = !sc_q[c][BIT_MSA];
                end
                MODE_CAPTURE: begin
                    if (((rise && sc_q[c][BIT_ELSL]) ||
                         (fall && sc_q[c][BIT_ELSH])) && !block_q[c]) begin
                        event_hit = 1'b1;
                        val_d[c]  = I_COUNT;
                    end
                end
                MODE_COMPARE: begin
                    ovf_act = I_OVERFLOW && sc_q[c][BIT_TOV];
                    if (I_TICK && (I_COUNT == cmp_val) && !inhib_q[c]) begin
                        event_hit = 1'b1;
                    end
                    if (ovf_act) begin
                        pin_d[c] = maxeff_q[c] ? 1'b1 : !pin_q[c];
                    end else if (event_hit && !(sc_q[c][BIT_TOV] && maxeff_q[c])) begin
                        unique case (sc_q[c][BIT_ELSH:BIT_ELSL])
                            2'h1:    pin_d[c] = !pin_q[c];
                            2'h2:    pin_d[c] = 1'b0;
                            default: pin_d[c] = 1'b1;
                        endcase
                    end
                end
            endcase
            // register writes
            if (wr_en && live && (wr_idx == 3'(c))) begin
                sc_d[c][6:0] = wbyte_q[6:0];
                if (c != 0) begin
                    sc_d[c][BIT_MSB] = 1'b0;
                end
                if (!wbyte_q[BIT_FLAG] && armed_q[c] && !event_hit) begin
                    sc_d[c][BIT_FLAG] = 1'b0;
                    armed_d[c]        = 1'b0;
                end
            end
            if (wr_en && (wr_idx == 3'(2 + 2 * c))) begin
                val_d[c][15:8] = wbyte_q;
                inhib_d[c]     = (mode == MODE_COMPARE);
            end
            if (wr_en && (wr_idx == 3'(3 + 2 * c))) begin
                val_d[c][7:0] = wbyte_q;
                inhib_d[c]    = 1'b0;
            end
            // register reads
            if (rd_en && live && (rd_idx == 3'(c)) && sc_q[c][BIT_FLAG]) begin
                armed_d[c] = 1'b1;
            end
            if (rd_en && (rd_idx == 3'(2 + 2 * c)) && (mode == MODE_CAPTURE)) begin
                block_d[c] = 1'b1;
            end
            if (rd_en && (rd_idx == 3'(3 + 2 * c))) begin
                block_d[c] = 1'b0;
            end
            // a coincident event outranks the clear
            if (event_hit) begin
                sc_d[c][BIT_FLAG] = 1'b1;
                armed_d[c]        = 1'b0;
            end
            // drive the pin only in compare modes
            oe_d[c]  = (mode == MODE_COMPARE);
            irq_d[c] = sc_d[c][BIT_FLAG] && sc_d[c][BIT_IE] && live;
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            for (int c = 0; c < NCH; c++) begin
                sc_q[c]  <= SC_RESET;
                val_q[c] <= 16'h0000;
            end
            shadow_q <= 16'h0000;
            armed_q  <= '0;
            block_q  <= '0;
            inhib_q  <= '0;
            maxeff_q <= '0;
            pin_q    <= '1;
            oe_q     <= '0;
            irq_q    <= '0;
            lvl_q    <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                sc_q[c]  <= sc_d[c];
                val_q[c] <= val_d[c];
            end
            shadow_q <= shadow_d;
            armed_q  <= armed_d;
            block_q  <= block_d;
            inhib_q  <= inhib_d;
            maxeff_q <= maxeff_d;
            pin_q    <= pin_d;
            oe_q     <= oe_d;
            irq_q    <= irq_d;
            lvl_q    <= lvl_d;
        end
    end

    // =====================================================
    // outputs
    assign O_PIN_OUT = pin_q;
    assign O_PIN_OE  = oe_q;
    assign O_IRQ     = irq_q;
    assign O_AWREADY = awready_q;
    assign O_WREADY  = wready_q;
    assign O_BVALID  = bvalid_q;
    assign O_BRESP   = bresp_q;
    assign O_ARREADY = arready_q;
    assign O_RVALID  = rvalid_q;
    assign O_RDATA   = rdata_q;
    assign O_RRESP   = rresp_q;

endmodule // tcc_top

//--- common/tcc_pkg.sv
// Notes on behaviour
// - capture edge sets the channel event flag
// - counter equal to value sets flag
// - clear flag: read while set, write zero
// - new event between steps voids the clear
// - reset clears flag; writing one ignored
// - irq only while enable and flag set
// - channel 0 buffer bit disables channel 1
// - mode bit A picks compare or capture
// - edge bits zero: pin free, preset level
// - capture edges: rising, falling, or both
// - compare action: toggle, low, or high
// - reset clears mode, edge, buffer, toggle bits
// - overflow toggles pin in compare mode only
// - overflow action beats coincident compare action
// - full duty force, effective next period
// - value registers hold capture or compare value
// - high byte read blocks capture until low
// - high byte write blocks compare until low
// - overflow arrives as a pulse input
package tcc_pkg;

    // =====================================================
    // register byte offsets
    localparam logic [7:0] OFS_SC0  = 8'h00;
    localparam logic [7:0] OFS_SC1  = 8'h04;
    localparam logic [7:0] OFS_HI0  = 8'h08;
    localparam logic [7:0] OFS_LO0  = 8'h0C;
    localparam logic [7:0] OFS_HI1  = 8'h10;
    localparam logic [7:0] OFS_LO1  = 8'h14;

    // =====================================================
    // status/control field positions
    localparam int BIT_FLAG = 7;
    localparam int BIT_IE   = 6;
    localparam int BIT_MSB  = 5;
    localparam int BIT_MSA  = 4;
    localparam int BIT_ELSH = 3;
    localparam int BIT_ELSL = 2;
    localparam int BIT_TOV  = 1;
    localparam int BIT_MAX  = 0;

    // =====================================================
    // reset values and answers
    localparam logic [7:0] SC_RESET   = 8'h00;
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_ERR   = 2'h2;
    localparam logic [2:0] IDX_NONE   = 3'h7;

    typedef enum logic [1:0] {
        MODE_PRESET  = 2'h0,
        MODE_CAPTURE = 2'h1,
        MODE_COMPARE = 2'h3
    } tcc_mode_type;

endpackage

//--- testbench/tcc_properties.sv
module tcc_properties
    import tcc_pkg::*;
#(
    parameter int NCH = 2
) (
    input wire logic           I_CLK,
    input wire logic           I_RST,
    input wire logic           I_TICK,
    input wire logic           I_OVERFLOW,
    input wire logic [NCH-1:0] O_PIN_OUT,
    input wire logic [NCH-1:0] O_PIN_OE,
    input wire logic [NCH-1:0] O_IRQ,
    input wire logic           I_AWVALID,
    input wire logic           O_AWREADY,
    input wire logic           I_WVALID,
    input wire logic           O_WREADY,
    input wire logic           O_BVALID,
    input wire logic           I_BREADY,
    input wire logic [7:0]     I_ARADDR,
    input wire logic           I_ARVALID,
    input wire logic           O_ARREADY,
    input wire logic [31:0]    O_RDATA,
    input wire logic [1:0]     O_RRESP,
    input wire logic           O_RVALID,
    input wire logic           I_RREADY
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    // =====================================================
    // sequences
    sequence s_wtake;
        I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
    endsequence
    sequence s_bdone;
        ##2 O_BVALID;
    endsequence
    // =====================================================
    // assertions
    a_reset_quiet: assert property ($fell(I_RST) |-> O_PIN_OE == '0 && O_IRQ == '0)
        else $error("outputs not quiet after reset");
    a_irq_clear: assert property ($fell(O_IRQ[0]) |-> O_BVALID || $past(O_BVALID))
        else $error("irq fell without a write");
    a_pin_action: assert property (O_PIN_OE[0] && $past(O_PIN_OE[0]) && $changed(O_PIN_OUT[0])
        |-> $past(I_TICK) || $past(I_OVERFLOW) || O_BVALID || $past(O_BVALID))
        else $error("pin moved without cause");
    a_oe_write: assert property ($changed(O_PIN_OE) |-> O_BVALID || $past(O_BVALID))
        else $error("pin enable moved without a write");
    a_rd_answer: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
        else $error("read answer late");
    a_rd_hold: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
        else $error("read data not held");
    a_rd_unmapped: assert property (I_ARVALID && O_ARREADY && I_ARADDR > 8'h14
        |=> O_RRESP == RESP_ERR && O_RDATA == '0)
        else $error("unmapped read not refused");
    a_rd_upper: assert property (O_RVALID |-> O_RDATA[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    a_wr_answer: assert property (s_wtake |-> s_bdone)
        else $error("write answer late");
    a_wr_busy: assert property (s_wtake |=> !O_AWREADY && !O_WREADY)
        else $error("write ready during write");
endmodule // tcc_properties

bind tcc_top tcc_properties #(.NCH(NCH)) u_props (
    .I_CLK(I_CLK), .I_RST(I_RST), .I_TICK(I_TICK), .I_OVERFLOW(I_OVERFLOW),
    .O_PIN_OUT(O_PIN_OUT), .O_PIN_OE(O_PIN_OE), .O_IRQ(O_IRQ), .I_AWVALID(I_AWVALID),
    .O_AWREADY(O_AWREADY), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BVALID(O_BVALID),
    .I_BREADY(I_BREADY), .I_ARADDR(I_ARADDR), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY),
    .O_RDATA(O_RDATA), .O_RRESP(O_RRESP), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY));

//--- testbench/tcc_pin_model.sv
module tcc_pin_model (
    input  wire logic [1:0] i_drive,
    input  wire logic [1:0] i_pin_out,
    input  wire logic [1:0] i_pin_oe,
    output logic      [1:0] o_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // channel drives when enabled, else the outside level
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            o_pin[i] = i_pin_oe[i] ? i_pin_out[i] : i_drive[i];
        end
    end
endmodule // tcc_pin_model

//--- testbench/tb.sv
module tb import tcc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0, rst = 1, tick = 0, ovf = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic        bv, rv, awr, wrr, arr;
    logic [15:0] cnt = 16'h0000;
    logic [1:0]  pin, pout, poe, irq, bresp, rresp, drv = 2'h0;
    logic [7:0]  awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h00000000, rdat;
    int          n_mismatch = 0, checks = 0;

    always #25 clk = ~clk;

    tcc_top dut (.I_CLK(clk), .I_RST(rst), .I_COUNT(cnt), .I_TICK(tick), .I_OVERFLOW(ovf),
        .I_PIN(pin), .O_PIN_OUT(pout), .O_PIN_OE(poe), .O_IRQ(irq), .I_AWADDR(awa),
        .I_AWVALID(awv), .O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(4'hF), .I_WVALID(wv),
        .O_WREADY(wrr), .O_BRESP(bresp), .O_BVALID(bv), .I_BREADY(br), .I_ARADDR(ara),
        .I_ARVALID(arv), .O_ARREADY(arr), .O_RDATA(rdat), .O_RRESP(rresp), .O_RVALID(rv),
        .I_RREADY(rr));
    tcc_pin_model u_pins (.i_drive(drv), .i_pin_out(pout), .i_pin_oe(poe), .o_pin(pin));

    // =====================================================
    // shared tasks
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        logic ta, tw;
        ta = 0;
        tw = 0;
        @(posedge clk);
        awa <= a;
        wd <= {24'h000000, d};
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do begin
            @(posedge clk);
            ta = ta | awr;
            tw = tw | wrr;
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end while (!(ta && tw));
        while (!bv) @(posedge clk);
        br <= 1'b0;
        chk("bresp", {30'h0, bresp}, {30'h0, (a > OFS_LO1) ? RESP_ERR : RESP_OKAY});
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do @(posedge clk); while (!arr);
        arv <= 1'b0;
        while (!rv) @(posedge clk);
        rr <= 1'b0;
        chk(nm, rdat, e);
        chk("rresp", {30'h0, rresp}, {30'h0, (a > OFS_LO1) ? RESP_ERR : RESP_OKAY});
    endtask

    task automatic pin_set(input logic v, input logic [15:0] c);
        @(posedge clk);
        drv[0] <= v;
        cnt <= c;
        repeat (6) @(posedge clk);
    endtask

    task automatic fire(input logic [15:0] c, input logic o);
        @(posedge clk);
        cnt <= c;
        tick <= 1'b1;
        ovf <= o;
        @(posedge clk);
        tick <= 1'b0;
        ovf <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    // =====================================================
    // scenarios
    task automatic t_reset();
        rd_chk(OFS_SC0, 0, "sc0 reset");
        rd_chk(OFS_SC1, 0, "sc1 reset");
        chk("oe reset", poe, 0);
        chk("irq reset", irq, 0);
        rd_chk(8'h20, 0, "unmapped");
        bus_wr(8'h20, 8'hFF);
        chk("pin reset", pout, 2'h3);
        $display("reset test done");
    endtask

    task automatic t_capture();
        logic [1:0] m;
        for (int i = 1; i < 4; i++) begin
            m = i[1:0];
            bus_wr(OFS_SC0, {4'h4, m, 2'h0});
            pin_set(1'b1, 16'h0000);
            rd_chk(OFS_SC0, {m[0], 3'h4, m, 2'h0}, "rise flag");
            chk("rise irq", irq[0], m[0]);
            bus_wr(OFS_SC0, {4'h4, m, 2'h0});
            pin_set(1'b0, 16'h0000);
            rd_chk(OFS_SC0, {m[1], 3'h4, m, 2'h0}, "fall flag");
            bus_wr(OFS_SC0, {4'h4, m, 2'h0});
        end
        pin_set(1'b1, 16'h1234);
        rd_chk(OFS_HI0, 8'h12, "cap high");
        pin_set(1'b0, 16'h5678);
        rd_chk(OFS_LO0, 8'h34, "cap low held");
        bus_wr(OFS_SC0, 8'hCC);
        rd_chk(OFS_SC0, 8'hCC, "write one");
        pin_set(1'b1, 16'h0000);
        bus_wr(OFS_SC0, 8'h4C);
        rd_chk(OFS_SC0, 8'hCC, "clear voided");
        bus_wr(OFS_SC0, 8'h4C);
        rd_chk(OFS_SC0, 8'h4C, "cleared");
        chk("irq cleared", irq[0], 0);
        bus_wr(OFS_SC0, 8'hCC);
        rd_chk(OFS_SC0, 8'h4C, "one ignored");
        $display("capture test done");
    endtask

    task automatic t_compare();
        bus_wr(OFS_SC0, 8'h10);
        bus_wr(OFS_SC0, 8'h1C);
        bus_wr(OFS_HI0, 8'h00);
        bus_wr(OFS_LO0, 8'h40);
        chk("oe compare", poe[0], 1);
        fire(16'h0040, 0);
        chk("set on match", pout[0], 1);
        bus_wr(OFS_SC0, 8'h18);
        fire(16'h0040, 0);
        chk("clear on match", pout[0], 0);
        bus_wr(OFS_SC0, 8'h14);
        fire(16'h0041, 0);
        chk("no match", pout[0], 0);
        fire(16'h0040, 0);
        chk("toggle on match", pout[0], 1);
        rd_chk(OFS_SC0, 8'h94, "compare flag");
        bus_wr(OFS_HI0, 8'h01);
        fire(16'h0140, 0);
        chk("match held off", pout[0], 1);
        bus_wr(OFS_LO0, 8'h40);
        fire(16'h0140, 0);
        chk("match released", pout[0], 0);
        bus_wr(OFS_SC0, 8'h1A);
        fire(16'h0140, 1);
        chk("overflow wins", pout[0], 1);
        fire(16'h0000, 1);
        chk("overflow toggle", pout[0], 0);
        bus_wr(OFS_SC0, 8'h1B);
        fire(16'h0000, 1);
        fire(16'h0000, 1);
        fire(16'h0140, 0);
        chk("full duty", pout[0], 1);
        bus_wr(OFS_SC0, 8'h10);
        @(posedge clk);
        chk("released", poe[0], 0);
        chk("preset low", pout[0], 0);
        bus_wr(OFS_SC0, 8'h00);
        @(posedge clk);
        chk("preset high", pout[0], 1);
        $display("compare test done");
    endtask

    task automatic t_buffer();
        bus_wr(OFS_SC1, 8'h44);
        bus_wr(OFS_SC0, 8'h20);
        bus_wr(OFS_SC1, 8'h48);
        rd_chk(OFS_SC1, 0, "sc1 hidden");
        rd_chk(OFS_SC0, 8'hA0, "buffer bit");
        bus_wr(OFS_SC0, 8'h28);
        bus_wr(OFS_LO0, 8'h50);
        chk("buffered oe", poe, 2'h1);
        fire(16'h0150, 0);
        chk("shadow held", pout[0], 1);
        fire(16'h0000, 1);
        fire(16'h0150, 0);
        chk("buffered match", pout[0], 0);
        bus_wr(OFS_SC0, 8'h00);
        rd_chk(OFS_SC1, 8'h44, "sc1 kept");
        $display("buffer test done");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_capture();
        t_compare();
        t_buffer();
        tally_and_finish();
    end

    initial begin
        #2000000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule // tb
